//--- inc/bvs_pkg.sv
package bvs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE   = 8'h02;
  localparam logic [7:0] ADDR_SRC_POS  = 8'h03;
  localparam logic [7:0] ADDR_GATE_POS = 8'h04;
  localparam logic [7:0] ADDR_GATE_NEG = 8'h05;

  // ----------------------------------------------------------------
  // field positions, widths and reset values
  // ----------------------------------------------------------------
  localparam int         BIT_BL_EN        = 1;
  localparam int         BIT_PHASE_SEL    = 0;
  localparam int         GATE_POS_W       = 6;
  localparam int         GATE_NEG_W       = 5;
  localparam logic [7:0] RST_ENABLE       = 8'h01;
  localparam logic [7:0] RST_SRC_POS      = 8'h14;
  localparam logic [5:0] RST_GATE_POS     = 6'h00;
  localparam logic [4:0] RST_GATE_NEG     = 5'h00;

  // ----------------------------------------------------------------
  // voltage code encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] SRC_POS_MIN_CODE = 8'h0A;  // 5.0 V
  localparam logic [7:0] SRC_POS_MAX_CODE = 8'h6E;  // 15.0 V
  localparam logic [5:0] GATE_POS_MAX     = 6'h28;  // 28 V
  localparam logic [4:0] GATE_NEG_MAX     = 5'h1F;  // -21.5 V
  localparam logic [7:0] SRC_POS_BASE_DV  = 8'h32;  // 5.0 V in 0.1 V
  localparam logic [7:0] GATE_POS_BASE_HV = 8'h10;  // 8 V in 0.5 V
  localparam logic [7:0] GATE_NEG_BASE_HV = 8'h0C;  // 6 V in 0.5 V

  // ----------------------------------------------------------------
  // backlight sequencer states (gray along the path)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BVS_BL_OFF  = 2'b00,
    BVS_BL_WAIT = 2'b01,
    BVS_BL_ON   = 2'b11
  } bvs_bl_state_t;

  // register write request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } bvs_wr_t;

  // voltage targets handed to the analog section
  typedef struct packed {
    logic [7:0] src_pos_dv;   // positive source, units of 0.1 V
    logic [7:0] gate_pos_hv;  // positive gate, units of 0.5 V
    logic [7:0] gate_neg_hv;  // negative gate magnitude, units of 0.5 V
  } bvs_volt_t;

endpackage

//--- rtl/bvs_volt_dec.sv
`timescale 1ns/1ps
// code-to-voltage decoding for the three bias settings
module bvs_volt_dec (
  input  wire logic [7:0]        src_code_i,
  input  wire logic [5:0]        gpos_code_i,
  input  wire logic [4:0]        gneg_code_i,
  output bvs_pkg::bvs_volt_t     volt_o
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // clamp then offset: codes below 0xA clamp to 5 V, above 0x6E to 15 V
  always_comb begin
    logic [7:0] c;
    c = src_code_i;
    if (c > bvs_pkg::SRC_POS_MAX_CODE) begin
      c = bvs_pkg::SRC_POS_MAX_CODE;
    end else if (c < bvs_pkg::SRC_POS_MIN_CODE) begin
      c = bvs_pkg::SRC_POS_MIN_CODE;
    end
    volt_o.src_pos_dv  = c - bvs_pkg::SRC_POS_MIN_CODE + bvs_pkg::SRC_POS_BASE_DV;
    // unused gate codes pass through unclamped; the analog side ignores them
    volt_o.gate_pos_hv = {2'h0, gpos_code_i} + bvs_pkg::GATE_POS_BASE_HV;
    volt_o.gate_neg_hv = {3'h0, gneg_code_i} + bvs_pkg::GATE_NEG_BASE_HV;
  end

endmodule // bvs_volt_dec

//--- rtl/bvs_regs.sv
`timescale 1ns/1ps
module bvs_regs (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  input  bvs_pkg::bvs_wr_t       wr_i,
  input  wire logic [7:0]        rd_addr_i,
  output logic [7:0]             rd_data_o,
  input  wire logic              tft_ss_done_i,
  output logic                   bl_run_o,
  output logic                   bl_phase_o,
  output bvs_pkg::bvs_volt_t     volt_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1;
  logic rst_b;

  // two-stage release of the asynchronous reset
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1 <= 1'b0;
      rst_b  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_b  <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // soft-start done synchroniser
  // ----------------------------------------------------------------
  logic ss_meta;
  logic ss_done;

  // pin input, two flops before any use
  always_ff @(posedge clk_sys_i or negedge rst_b) begin
    if (!rst_b) begin
      ss_meta <= 1'b0;
      ss_done <= 1'b0;
    end else begin
      ss_meta <= tft_ss_done_i;
      ss_done <= ss_meta;
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic       bl_en;
  logic       phase_sel;
  logic [7:0] src_pos;
  logic [5:0] gate_pos;
  logic [4:0] gate_neg;
  logic       next_bl_en;
  logic       next_phase_sel;
  logic [7:0] next_src_pos;
  logic [5:0] next_gate_pos;
  logic [4:0] next_gate_neg;

  // write decode
  always_comb begin
    next_bl_en     = bl_en;
    next_phase_sel = phase_sel;
    next_src_pos   = src_pos;
    next_gate_pos  = gate_pos;
    next_gate_neg  = gate_neg;
    if (wr_i.wr) begin
      unique case (wr_i.addr)
        bvs_pkg::ADDR_ENABLE: begin
          next_bl_en     = wr_i.data[bvs_pkg::BIT_BL_EN];
          next_phase_sel = wr_i.data[bvs_pkg::BIT_PHASE_SEL];
        end
        bvs_pkg::ADDR_SRC_POS:  next_src_pos  = wr_i.data;
        bvs_pkg::ADDR_GATE_POS: next_gate_pos = wr_i.data[5:0];
        bvs_pkg::ADDR_GATE_NEG: next_gate_neg = wr_i.data[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b) begin
    if (!rst_b) begin
      bl_en     <= bvs_pkg::RST_ENABLE[bvs_pkg::BIT_BL_EN];
      phase_sel <= bvs_pkg::RST_ENABLE[bvs_pkg::BIT_PHASE_SEL];
      src_pos   <= bvs_pkg::RST_SRC_POS;
      gate_pos  <= bvs_pkg::RST_GATE_POS;
      gate_neg  <= bvs_pkg::RST_GATE_NEG;
    end else begin
      bl_en     <= next_bl_en;
      phase_sel <= next_phase_sel;
      src_pos   <= next_src_pos;
      gate_pos  <= next_gate_pos;
      gate_neg  <= next_gate_neg;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] next_rd_data;

  // unmapped offsets and unused upper bits read as zero
  always_comb begin
    next_rd_data = 8'h00;
    unique case (rd_addr_i)
      bvs_pkg::ADDR_ENABLE:   next_rd_data = {6'h00, bl_en, phase_sel};
      bvs_pkg::ADDR_SRC_POS:  next_rd_data = src_pos;
      bvs_pkg::ADDR_GATE_POS: next_rd_data = {2'h0, gate_pos};
      bvs_pkg::ADDR_GATE_NEG: next_rd_data = {3'h0, gate_neg};
      default:                next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // backlight startup sequencer
  // ----------------------------------------------------------------
  bvs_pkg::bvs_bl_state_t state;
  bvs_pkg::bvs_bl_state_t next_state;
  logic                   phase_cap;
  logic                   next_phase_cap;

  // wait for soft-start, capture phase select once on entry to run
  always_comb begin
    next_state     = state;
    next_phase_cap = phase_cap;
    unique case (state)
      bvs_pkg::BVS_BL_OFF: begin
        if (bl_en) begin
          next_state = bvs_pkg::BVS_BL_WAIT;
        end
      end
      bvs_pkg::BVS_BL_WAIT: begin
        if (!bl_en) begin
          next_state = bvs_pkg::BVS_BL_OFF;
        end else if (ss_done) begin
          next_state     = bvs_pkg::BVS_BL_ON;
          next_phase_cap = phase_sel;
        end
      end
      bvs_pkg::BVS_BL_ON: begin
        if (!bl_en || !ss_done) begin
          next_state = bvs_pkg::BVS_BL_OFF;
        end
      end
      default: next_state = bvs_pkg::BVS_BL_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b) begin
    if (!rst_b) begin
      state     <= bvs_pkg::BVS_BL_OFF;
      phase_cap <= 1'b0;
    end else begin
      state     <= next_state;
      phase_cap <= next_phase_cap;
    end
  end

  assign bl_run_o   = (state == bvs_pkg::BVS_BL_ON);
  assign bl_phase_o = phase_cap;

  // ----------------------------------------------------------------
  // voltage decode
  // ----------------------------------------------------------------
  bvs_volt_dec u_dec (
    .src_code_i  (src_pos),
    .gpos_code_i (gate_pos),
    .gneg_code_i (gate_neg),
    .volt_o      (volt_o)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // run lags enable and soft-start by one edge, so both are judged one cycle back
  AST_RUN_NEEDS_SS: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    bl_run_o |-> ($past(bl_en) && $past(ss_done)))
    else $error("backlight on without soft-start");
  AST_RUN_STARTS: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (state == bvs_pkg::BVS_BL_WAIT && bl_en && ss_done) |=> bl_run_o)
    else $error("backlight did not start");
  AST_PHASE_HELD: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (bl_run_o && $past(bl_run_o)) |-> $stable(bl_phase_o))
    else $error("phase changed while running");
  AST_PHASE_CAPT: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    $rose(bl_run_o) |-> (bl_phase_o == $past(phase_sel)))
    else $error("phase not captured at startup");
  AST_SRC_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (wr_i.wr && wr_i.addr == bvs_pkg::ADDR_SRC_POS) |=> (src_pos == $past(wr_i.data)))
    else $error("source code not stored");
  AST_SRC_SAT: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (src_pos > bvs_pkg::SRC_POS_MAX_CODE) |-> (volt_o.src_pos_dv == 8'h96))
    else $error("source code not saturated at 15 V");
  AST_GPOS_MAP: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (gate_pos == bvs_pkg::GATE_POS_MAX) |-> (volt_o.gate_pos_hv == 8'h38))
    else $error("gate positive 28 V wrong");
  AST_GNEG_MAP: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (gate_neg == bvs_pkg::GATE_NEG_MAX) |-> (volt_o.gate_neg_hv == 8'h2B))
    else $error("gate negative -21.5 V wrong");
  AST_READ_GPOS: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (rd_addr_i == bvs_pkg::ADDR_GATE_POS) |=> (rd_data_o == {2'h0, $past(gate_pos)}))
    else $error("gate positive readback wrong");

  COV_START_DIRECT: cover property (@(posedge clk_sys_i) disable iff (!rst_b)
    $rose(bl_run_o) && !bl_phase_o);
  COV_START_PHASE: cover property (@(posedge clk_sys_i) disable iff (!rst_b)
    $rose(bl_run_o) && bl_phase_o);
  COV_LATE_WRITE: cover property (@(posedge clk_sys_i) disable iff (!rst_b)
    bl_run_o && wr_i.wr && wr_i.addr == bvs_pkg::ADDR_ENABLE);

endmodule // bvs_regs

//--- tb/bvs_host_model.sv
`timescale 1ns/1ps
// host side of the register port: one write pulse or one read at a time
module bvs_host_model (
  input  wire logic        clk_sys_i,
  output bvs_pkg::bvs_wr_t wr_o,
  output logic [7:0]       rd_addr_o,
  input  wire logic [7:0]  rd_data_i
);
  // idle port after time zero
  initial begin
    wr_o = '0;
    rd_addr_o = 8'h00;
  end

  // single write pulse; address and data turn over once released
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys_i);
    wr_o <= '{wr: 1'b1, addr: addr, data: data};
    @(posedge clk_sys_i);
    wr_o <= '{wr: 1'b0, addr: ~addr, data: ~data};
  endtask

  // read: address held two edges so the registered data has landed
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys_i);
    rd_addr_o <= addr;
    repeat (2) @(posedge clk_sys_i);
    #1;
    data = rd_data_i;
  endtask
endmodule // bvs_host_model

//--- tb/test_bias_voltage_setting_registers.sv
`timescale 1ns/1ps
module test_bias_voltage_setting_registers;
  logic               clk_sys_i = 1'b0;
  logic               rst_b_i = 1'b0;
  logic               tft_ss_done_i = 1'b0;
  bvs_pkg::bvs_wr_t   wr;
  logic [7:0]         rd_addr;
  logic [7:0]         rd_data;
  logic               bl_run;
  logic               bl_phase;
  bvs_pkg::bvs_volt_t volt;
  int                 num_errors = 0;
  int                 check_count = 0;
  int                 cycles = 0;
  logic [7:0]         c;
  logic [7:0]         src_codes [7] = '{8'h00, 8'h0A, 8'h0B, 8'h14, 8'h6E, 8'h6F, 8'hFF};
  logic [7:0]         pos_codes [5] = '{8'h00, 8'h01, 8'h28, 8'h29, 8'hC5};
  logic [7:0]         neg_codes [4] = '{8'h00, 8'h01, 8'h1F, 8'hE3};

  // 25 MHz clock
  always #20 clk_sys_i = ~clk_sys_i;

  bvs_regs dut (
    .clk_sys_i     (clk_sys_i),
    .rst_b_i       (rst_b_i),
    .wr_i          (wr),
    .rd_addr_i     (rd_addr),
    .rd_data_o     (rd_data),
    .tft_ss_done_i (tft_ss_done_i),
    .bl_run_o      (bl_run),
    .bl_phase_o    (bl_phase),
    .volt_o        (volt)
  );

  bvs_host_model host (
    .clk_sys_i (clk_sys_i),
    .wr_o      (wr),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data)
  );

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(addr, d);
    chk($sformatf("reg %h", addr), exp, d);
  endtask

  // expected source target in 0.1 V units, clamped at both ends
  function automatic logic [7:0] src_exp(input logic [7:0] code);
    if (code < 8'h0A) return 8'h32;
    if (code > 8'h6E) return 8'h96;
    return code + 8'h28;
  endfunction

  // wait a bounded time for the backlight to come up
  task automatic wait_run();
    for (int i = 0; i < 10 && bl_run !== 1'b1; i++) @(negedge clk_sys_i);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      $display("BAD run length expected below 4000 seen 4000");
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd_chk(bvs_pkg::ADDR_ENABLE, 8'h01);
    rd_chk(bvs_pkg::ADDR_SRC_POS, 8'h14);
    rd_chk(bvs_pkg::ADDR_GATE_POS, 8'h00);
    rd_chk(bvs_pkg::ADDR_GATE_NEG, 8'h00);
    rd_chk(8'h07, 8'h00);
    chk("src volt", 8'h3C, volt.src_pos_dv);
    chk("gpos volt", 8'h10, volt.gate_pos_hv);
    chk("gneg volt", 8'h0C, volt.gate_neg_hv);
    $display("test reset values done");
    foreach (src_codes[i]) begin
      c = src_codes[i];
      host.write_reg(bvs_pkg::ADDR_SRC_POS, c);
      @(negedge clk_sys_i);
      chk("src volt", src_exp(c), volt.src_pos_dv);
      rd_chk(bvs_pkg::ADDR_SRC_POS, c);
    end
    host.write_reg(8'h07, 8'h55);
    rd_chk(bvs_pkg::ADDR_SRC_POS, 8'hFF);
    $display("test source codes done");
    foreach (pos_codes[i]) begin
      c = pos_codes[i];
      host.write_reg(bvs_pkg::ADDR_GATE_POS, c);
      @(negedge clk_sys_i);
      chk("gpos volt", 8'h10 + (c & 8'h3F), volt.gate_pos_hv);
      rd_chk(bvs_pkg::ADDR_GATE_POS, c & 8'h3F);
    end
    foreach (neg_codes[i]) begin
      c = neg_codes[i];
      host.write_reg(bvs_pkg::ADDR_GATE_NEG, c);
      @(negedge clk_sys_i);
      chk("gneg volt", 8'h0C + (c & 8'h1F), volt.gate_neg_hv);
      rd_chk(bvs_pkg::ADDR_GATE_NEG, c & 8'h1F);
    end
    $display("test gate codes done");
    host.write_reg(bvs_pkg::ADDR_ENABLE, 8'h03);
    repeat (10) @(negedge clk_sys_i);
    chk("run before soft-start", 8'h00, {7'h00, bl_run});
    @(posedge clk_sys_i);
    tft_ss_done_i <= 1'b1;
    wait_run();
    chk("run", 8'h01, {7'h00, bl_run});
    chk("phase", 8'h01, {7'h00, bl_phase});
    host.write_reg(bvs_pkg::ADDR_ENABLE, 8'h02);
    repeat (3) @(negedge clk_sys_i);
    chk("phase after write", 8'h01, {7'h00, bl_phase});
    rd_chk(bvs_pkg::ADDR_ENABLE, 8'h02);
    host.write_reg(bvs_pkg::ADDR_ENABLE, 8'h00);
    repeat (3) @(negedge clk_sys_i);
    chk("run off", 8'h00, {7'h00, bl_run});
    host.write_reg(bvs_pkg::ADDR_ENABLE, 8'h02);
    wait_run();
    chk("run again", 8'h01, {7'h00, bl_run});
    chk("phase direct", 8'h00, {7'h00, bl_phase});
    @(posedge clk_sys_i);
    tft_ss_done_i <= 1'b0;
    repeat (6) @(negedge clk_sys_i);
    chk("run lost soft-start", 8'h00, {7'h00, bl_run});
    $display("test backlight done");
    give_verdict();
  end
endmodule // test_bias_voltage_setting_registers
